/* dosel_pkg.sv */
// Purpose: Constants for the digital output source selector
// Assumes: One control cycle per sys_clk edge
// Notes: Function
// Function
// R1 - Brake release code drives output from the brake control condition.
// R2 - Synchronization fault code asserts when index phase error exceeds limit.
// R3 - Signal fault code asserts when index period too short during index control.
// R4 - Phasing done code asserts when gear phasing reached its offset.
// R5 - In-gear code asserts when follower is engaged at synchronous angle.
// R6 - Comparator code asserts between switch-on and switch-off with hysteresis.
// R7 - Homing done code asserts after reference travel set reference position.
// R8 - Target reached on orientation reached or window held for window time.
// R9 - Deviation warning code asserts when following error exceeds threshold.
// R10 - Motion-block codes 62-65 follow their programmed travel-order signal conditions.
// R11 - Buffer codes 80-83 drive values of sources 2401 to 2404.
// R12 - Codes 90-94 drive fieldbus bits, only with communication module fitted.
// R13 - Codes 100-194 select code minus 100 with inverted polarity.
// R14 - Unassigned codes deassert; outputs re-evaluated every cycle.
`default_nettype none

package dosel_pkg;
  localparam int NUM_OUT = 3;
  localparam int MODE_W = 8;
  localparam int POS_W = 32;
  localparam int WIN_TIME_W = 16;
  localparam logic [MODE_W-1:0] MODE_BRAKE = 8'h29;
  localparam logic [MODE_W-1:0] MODE_SYNC_FAULT = 8'h32;
  localparam logic [MODE_W-1:0] MODE_SIG_FAULT = 8'h33;
  localparam logic [MODE_W-1:0] MODE_PHASE_DONE = 8'h38;
  localparam logic [MODE_W-1:0] MODE_IN_GEAR = 8'h39;
  localparam logic [MODE_W-1:0] MODE_POS_CMP = 8'h3A;
  localparam logic [MODE_W-1:0] MODE_HOME_DONE = 8'h3B;
  localparam logic [MODE_W-1:0] MODE_TARGET = 8'h3C;
  localparam logic [MODE_W-1:0] MODE_DEV_WARN = 8'h3D;
  localparam logic [MODE_W-1:0] MODE_BLOCK_FIRST = 8'h3E;
  localparam logic [MODE_W-1:0] MODE_BLOCK_LAST = 8'h41;
  localparam logic [MODE_W-1:0] MODE_BUF_FIRST = 8'h50;
  localparam logic [MODE_W-1:0] MODE_BUF_LAST = 8'h53;
  localparam logic [MODE_W-1:0] MODE_BUS_FIRST = 8'h5A;
  localparam logic [MODE_W-1:0] MODE_BUS_LAST = 8'h5E;
  localparam logic [MODE_W-1:0] MODE_INV_FIRST = 8'h64;
  localparam logic [MODE_W-1:0] MODE_INV_LAST = 8'hC2;
  localparam logic [MODE_W-1:0] MODE_INV_OFFSET = 8'h64;
  localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
  localparam logic [WIN_TIME_W-1:0] WIN_CNT_RESET = 16'h0000;
endpackage

`default_nettype wire

/* dosel_target_window.sv */
// Purpose: Measures how long the position stays inside the target window
// Assumes: Window time given in control cycles
// Notes: Count saturates once the window time is met
`default_nettype none

module dosel_target_window
  import dosel_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Position inputs
  input wire logic [POS_W-1:0] actPos,
  input wire logic [POS_W-1:0] targetPos,
  input wire logic [POS_W-1:0] targetWindow,
  input wire logic [WIN_TIME_W-1:0] windowTime,
  // Result
  output logic inTargetLong
);
  logic [WIN_TIME_W-1:0] dwellCnt;
  logic [WIN_TIME_W-1:0] next_dwellCnt;
  logic [POS_W-1:0] posDiff;
  logic insideWin;
  logic timeMet;

  assign posDiff = ($signed(actPos) >= $signed(targetPos)) ?
                   (actPos - targetPos) : (targetPos - actPos);
  assign insideWin = posDiff <= targetWindow;
  assign timeMet = dwellCnt >= windowTime;
  assign next_dwellCnt = !insideWin ? WIN_CNT_RESET :
                         (timeMet ? dwellCnt : dwellCnt + 16'h0001);

  // ----------------------------------------
  // Dwell counter
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dwellCnt <= WIN_CNT_RESET;
      inTargetLong <= 1'b0;
    end else begin
      dwellCnt <= next_dwellCnt;
      inTargetLong <= insideWin && timeMet; // [R8]
    end
  end
endmodule

`default_nettype wire

/* dosel_pos_comparator.sv */
// Purpose: Position comparator with hysteresis
// Assumes: Switch-on below switch-off position, signed positions
// Notes: Hysteresis widens the band once the output is on
`default_nettype none

module dosel_pos_comparator
  import dosel_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Settings
  input wire logic [POS_W-1:0] actPos,
  input wire logic [POS_W-1:0] switchOnPos,
  input wire logic [POS_W-1:0] switchOffPos,
  input wire logic [POS_W-1:0] hysteresis,
  // Result
  output logic inRange
);
  logic [POS_W-1:0] lowEdge;
  logic [POS_W-1:0] highEdge;
  logic next_inRange;

  assign lowEdge = inRange ? switchOnPos - hysteresis : switchOnPos;
  assign highEdge = inRange ? switchOffPos + hysteresis : switchOffPos;
  assign next_inRange = ($signed(actPos) >= $signed(lowEdge)) &&
                        ($signed(actPos) <= $signed(highEdge));

  // ----------------------------------------
  // Range flag
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      inRange <= 1'b0;
    end else begin
      inRange <= next_inRange; // [R6]
    end
  end
endmodule

`default_nettype wire

/* dosel_top.sv */
// Purpose: Picks the internal condition reported on each digital output
// Assumes: Status inputs are synchronous to sys_clk
// Notes: Output is registered, one cycle behind its source
`default_nettype none

module dosel_top
  import dosel_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Mode selection per output
  input wire logic [NUM_OUT*MODE_W-1:0] outMode,
  // Brake and gear status
  input wire logic brakeRelease,
  input wire logic phaseError,
  input wire logic phaseWarnLimit,
  input wire logic indexRunning,
  input wire logic indexPeriodShort,
  input wire logic phasingDone,
  input wire logic gearEngaged,
  input wire logic gearSyncAngle,
  // Position status
  input wire logic [POS_W-1:0] actPos,
  input wire logic [POS_W-1:0] switchOnPos,
  input wire logic [POS_W-1:0] switchOffPos,
  input wire logic [POS_W-1:0] hysteresis,
  input wire logic homingStarted,
  input wire logic refPosSet,
  input wire logic orientReached,
  input wire logic [POS_W-1:0] targetPos,
  input wire logic [POS_W-1:0] targetWindow,
  input wire logic [WIN_TIME_W-1:0] windowTime,
  input wire logic [POS_W-1:0] followError,
  input wire logic [POS_W-1:0] followWarnThreshold,
  // Motion-block signals
  input wire logic [3:0] blockSignal,
  // Function table buffers
  input wire logic [3:0] functionTableBuffer,
  // Fieldbus
  input wire logic communicationModuleFitted,
  input wire logic [4:0] fieldbusOutputBit,
  // Outputs
  output logic [NUM_OUT-1:0] digitalOut
);
  logic cmpInRange;
  logic inTargetLong;
  logic syncFault;
  logic sigFault;
  logic inGear;
  logic homeDone;
  logic targetReached;
  logic devWarn;

  dosel_pos_comparator u_cmp (
    .sys_clk(sys_clk),
    .srst(srst),
    .actPos(actPos),
    .switchOnPos(switchOnPos),
    .switchOffPos(switchOffPos),
    .hysteresis(hysteresis),
    .inRange(cmpInRange)
  );

  dosel_target_window u_win (
    .sys_clk(sys_clk),
    .srst(srst),
    .actPos(actPos),
    .targetPos(targetPos),
    .targetWindow(targetWindow),
    .windowTime(windowTime),
    .inTargetLong(inTargetLong)
  );

  // ----------------------------------------
  // Condition decoding
  // ----------------------------------------
  assign syncFault = phaseError && phaseWarnLimit; // [R2]
  assign sigFault = indexRunning && indexPeriodShort; // [R3]
  assign inGear = gearEngaged && gearSyncAngle; // [R5]
  assign homeDone = homingStarted && refPosSet; // [R7]
  assign targetReached = orientReached || inTargetLong; // [R8]
  assign devWarn = followError > followWarnThreshold; // [R9]

  // ----------------------------------------
  // Per-output selection
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : gen_out
      logic [MODE_W-1:0] mode;
      logic inverted;
      logic [MODE_W-1:0] baseMode;
      logic [MODE_W-1:0] blockIdx;
      logic [MODE_W-1:0] bufIdx;
      logic [MODE_W-1:0] busIdx;
      logic srcVal;
      logic next_out;

      assign mode = outMode[g*MODE_W +: MODE_W];
      assign inverted = (mode >= MODE_INV_FIRST) && (mode <= MODE_INV_LAST); // [R13]
      assign baseMode = inverted ? mode - MODE_INV_OFFSET : mode; // [R13]
      assign blockIdx = baseMode - MODE_BLOCK_FIRST;
      assign bufIdx = baseMode - MODE_BUF_FIRST;
      assign busIdx = baseMode - MODE_BUS_FIRST;

      always_comb begin
        case (baseMode)
          MODE_BRAKE: srcVal = brakeRelease; // [R1]
          MODE_SYNC_FAULT: srcVal = syncFault; // [R2]
          MODE_SIG_FAULT: srcVal = sigFault; // [R3]
          MODE_PHASE_DONE: srcVal = phasingDone; // [R4]
          MODE_IN_GEAR: srcVal = inGear; // [R5]
          MODE_POS_CMP: srcVal = cmpInRange; // [R6]
          MODE_HOME_DONE: srcVal = homeDone; // [R7]
          MODE_TARGET: srcVal = targetReached; // [R8]
          MODE_DEV_WARN: srcVal = devWarn; // [R9]
          default: begin
            if (baseMode >= MODE_BLOCK_FIRST && baseMode <= MODE_BLOCK_LAST) begin
              srcVal = blockSignal[blockIdx[1:0]]; // [R10]
            end else if (baseMode >= MODE_BUF_FIRST && baseMode <= MODE_BUF_LAST) begin
              srcVal = functionTableBuffer[bufIdx[1:0]]; // [R11]
            end else if (baseMode >= MODE_BUS_FIRST && baseMode <= MODE_BUS_LAST) begin
              srcVal = communicationModuleFitted && fieldbusOutputBit[busIdx[2:0]]; // [R12]
            end else begin
              srcVal = 1'b0; // [R14]
            end
          end
        endcase
      end

      assign next_out = inverted ? !srcVal : srcVal; // [R13]

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          digitalOut[g] <= 1'b0;
        end else begin
          digitalOut[g] <= next_out; // [R14]
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

/* dosel_relay_model.sv */
// Purpose: Relay contacts driven by the outputs
// Assumes: One cycle pull-in
// Notes: Contacts open in reset
`default_nettype none
module dosel_relay_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Coils and contacts
  input wire logic [2:0] digitalOut,
  output logic [2:0] relayClosed
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge sys_clk) begin
    relayClosed <= srst ? 3'h0 : digitalOut;
  end
endmodule
`default_nettype wire

/* dosel_checker_sva.sv */
// Purpose: Output 0 selection checks
// Assumes: One edge latency
// Notes: Bound below
`default_nettype none
module dosel_checker
  import dosel_pkg::*;
(
  // Watched ports
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [NUM_OUT*MODE_W-1:0] outMode,
  input wire logic brakeRelease,
  input wire logic phaseError,
  input wire logic phaseWarnLimit,
  input wire logic phasingDone,
  input wire logic orientReached,
  input wire logic [3:0] blockSignal,
  input wire logic [3:0] functionTableBuffer,
  input wire logic communicationModuleFitted,
  input wire logic [4:0] fieldbusOutputBit,
  input wire logic [NUM_OUT-1:0] digitalOut
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire logic [7:0] m0 = outMode[7:0];
  reset_low_a: assert property (disable iff (1'b0) srst |=> digitalOut == 3'h0)
    else $error("not low after reset");
  brake_out_a: assert property (m0 == 8'h29 |=> digitalOut[0] == $past(brakeRelease))
    else $error("brake mismatch");
  sync_flt_a: assert property (m0 == 8'h32 |=> digitalOut[0] == $past(phaseError & phaseWarnLimit))
    else $error("sync fault mismatch");
  phase_done_a: assert property (m0 == 8'h38 |=> digitalOut[0] == $past(phasingDone))
    else $error("phasing mismatch");
  orient_hit_a: assert property (m0 == 8'h3C && orientReached |=> digitalOut[0])
    else $error("target mismatch");
  block_sig_a: assert property (m0 inside {[8'h3E:8'h41]}
    |=> digitalOut[0] == $past(blockSignal[m0[1:0] + 2'h2])) else $error("block mismatch");
  ft_buf_a: assert property (m0 inside {[8'h50:8'h53]}
    |=> digitalOut[0] == $past(functionTableBuffer[m0[1:0]])) else $error("buffer mismatch");
  bus_bit_a: assert property (m0 inside {[8'h5A:8'h5E]} |=> digitalOut[0] ==
    $past(communicationModuleFitted & fieldbusOutputBit[m0[2:0] - 3'h2])) else $error("bus bit");
  brake_inv_a: assert property (m0 == 8'h8D |=> digitalOut[0] != $past(brakeRelease))
    else $error("inversion mismatch");
  unused_low_a: assert property (m0 == 8'h2A |=> !digitalOut[0])
    else $error("unassigned code high");
  cover property (m0 == 8'h29 ##1 digitalOut[0]);
  cover property (m0 == 8'h8D ##1 digitalOut[0]);
  cover property (m0 == 8'h5A && communicationModuleFitted);
endmodule
bind dosel_top dosel_checker chk_u (.sys_clk, .srst, .outMode, .brakeRelease, .phaseError,
  .phaseWarnLimit, .phasingDone, .orientReached, .blockSignal, .functionTableBuffer,
  .communicationModuleFitted, .fieldbusOutputBit, .digitalOut);
`default_nettype wire

/* test_digital_output_source_selector.sv */
// Purpose: Random and corner tests of the selector
// Assumes: Inputs driven 1 ns after the edge
// Notes: Comparator and window run by hand
`default_nettype none
module test_digital_output_source_selector
  import dosel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, srst = 1, brakeRelease = 0, phaseError = 0, phaseWarnLimit = 0;
  logic indexRunning = 0, indexPeriodShort = 0, phasingDone = 0, gearEngaged = 0;
  logic gearSyncAngle = 0, homingStarted = 0, refPosSet = 0, orientReached = 0;
  logic communicationModuleFitted = 0;
  logic [23:0] outMode = 24'h646464;
  logic [31:0] actPos = 0, switchOnPos = 0, switchOffPos = 0, hysteresis = 0, targetPos = 1;
  logic [31:0] targetWindow = 0, followError = 0, followWarnThreshold = 0, r;
  logic [31:0] lfsr = 32'h2237A8AF;
  logic [15:0] windowTime = 0;
  logic [3:0] blockSignal = 0, functionTableBuffer = 0;
  logic [4:0] fieldbusOutputBit = 0;
  logic [7:0] c;
  logic [2:0] e;
  wire logic [2:0] digitalOut, relayClosed;
  int mismatches = 0, checks = 0, cyc = 0;
  logic [7:0] tbl [16] = '{8'h29, 8'h32, 8'h33, 8'h38, 8'h39, 8'h3B, 8'h3D, 8'h3E, 8'h3F,
    8'h40, 8'h41, 8'h50, 8'h53, 8'h5A, 8'h5E, 8'h2B};
  dosel_top dut_u (.sys_clk, .srst, .outMode, .brakeRelease, .phaseError, .phaseWarnLimit,
    .indexRunning, .indexPeriodShort, .phasingDone, .gearEngaged, .gearSyncAngle, .actPos,
    .switchOnPos, .switchOffPos, .hysteresis, .homingStarted, .refPosSet, .orientReached,
    .targetPos, .targetWindow, .windowTime, .followError, .followWarnThreshold, .blockSignal,
    .functionTableBuffer, .communicationModuleFitted, .fieldbusOutputBit, .digitalOut);
  dosel_relay_model relay_u (.sys_clk, .srst, .digitalOut, .relayClosed);
  // ---------
  // Helpers
  // ---------
  always #10 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic ex(input logic [7:0] m);
    logic [7:0] b;
    logic s;
    b = (m >= 8'h64 && m <= 8'hC2) ? m - 8'h64 : m;
    case (b) inside
      8'h29: s = brakeRelease;
      8'h32: s = phaseError & phaseWarnLimit;
      8'h33: s = indexRunning & indexPeriodShort;
      8'h38: s = phasingDone;
      8'h39: s = gearEngaged & gearSyncAngle;
      8'h3B: s = homingStarted & refPosSet;
      8'h3C: s = orientReached;
      8'h3D: s = followError > followWarnThreshold;
      [8'h3E:8'h41]: s = blockSignal[b - 8'h3E];
      [8'h50:8'h53]: s = functionTableBuffer[b - 8'h50];
      [8'h5A:8'h5E]: s = communicationModuleFitted & fieldbusOutputBit[b - 8'h5A];
      default: s = 1'b0;
    endcase
    return s ^ (b != m);
  endfunction
  task chk(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t out %b exp %b", $time, got, exp);
    end
  endtask
  task step(input int n, input logic [31:0] pos, input logic exp);
    actPos = pos;
    repeat (n) @(posedge sys_clk);
    #1 chk(digitalOut, {2'b00, exp});
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 chk(digitalOut, 3'h0);
    srst = 0;
    for (int i = 0; i < 500; i++) begin
      @(posedge sys_clk);
      #1 if (i > 0) chk(digitalOut, e);
      for (int g = 0; g < 3; g++) begin
        r = rnd();
        c = r[9] ? tbl[r[13:10]] + (r[8] ? 8'h64 : 8'h00) : r[7:0];
        outMode[8*g +: 8] = (c == 8'h3A || c == 8'h9E) ? 8'h29 : c;
      end
      r = rnd();
      {brakeRelease, phaseError, phaseWarnLimit, indexRunning, indexPeriodShort, phasingDone,
        gearEngaged, gearSyncAngle, homingStarted, refPosSet, orientReached,
        communicationModuleFitted, blockSignal, functionTableBuffer, fieldbusOutputBit} = r[24:0];
      followError = rnd();
      followWarnThreshold = rnd();
      actPos = rnd();
      targetPos = ~actPos;
      windowTime = r[31:16];
      for (int g = 0; g < 3; g++) e[g] = ex(outMode[8*g +: 8]);
    end
    $display("random test done");
    outMode = 24'h00003A;
    {switchOnPos, switchOffPos, hysteresis} = {32'd100, 32'd200, 32'd10};
    step(2, 99, 0);
    step(2, 100, 1);
    step(2, 205, 1);
    step(2, 211, 0);
    step(2, 205, 0);
    $display("comparator test done");
    {outMode, orientReached, targetPos, targetWindow, windowTime} = {24'h3C, 1'b0, 32'd1000,
      32'd5, 16'd4};
    step(3, 2000, 0);
    step(5, 1003, 0);
    step(1, 1003, 1);
    $display("window test done");
    stop_test();
  end
endmodule
`default_nettype wire
